// ---- rsph_params.svh ----
// Constants for the receive sync and packet handler
//
// Contract
// RULE1 - CS gate freezes offset loop until carrier
// RULE2 - Separate loop gains before and after sync
// RULE3 - Offset compensation only for FSK formats
// RULE4 - Estimate readable; synth offset field shifts synth
// RULE5 - Bit timing from programmed rate, continuously adjusted
// RULE6 - 16 bit sync word, optionally doubled, MSB first
// RULE7 - Match at 15/16, 16/16 or 30/32
// RULE8 - With sync enabled, discard unmatched data
// RULE9 - Sync mode 3 or 7 searches doubled word
// RULE10 - Append RSSI then CRC status bytes
// RULE11 - First status byte is RSSI
// RULE12 - Second byte bit7 CRC ok, rest zero
// RULE13 - Software changes config only while idle
// RULE14 - Frame order: preamble, sync, length, address, payload, CRC
// RULE15 - Fixed mode receives packet length bytes
// RULE16 - Variable mode length byte, oversize discarded
// RULE17 - Infinite mode receives until stopped
// RULE18 - Fixed/variable packets 1 to 255 bytes
// RULE19 - Length writable during reception, counter compare ends
// RULE20 - Infinite to fixed switch ends at count
// RULE21 - Long packets: infinite, modulo length, then fixed
// RULE22 - CRC and append usable in long packets
// RULE23 - Oversize length restarts sync search always
// RULE24 - Byte counter cleared at sync detection
`ifndef RSPH_PARAMS_SVH
`define RSPH_PARAMS_SVH
`define RSPH_ADDR_SYNC_HIGH 8'h00
`define RSPH_ADDR_SYNC_LOW 8'h01
`define RSPH_ADDR_PKT_LEN 8'h02
`define RSPH_ADDR_PKT_CTRL 8'h03
`define RSPH_ADDR_MODEM 8'h04
`define RSPH_ADDR_OFFSET_CFG 8'h05
`define RSPH_ADDR_SYNTH_OFF 8'h06
`define RSPH_ADDR_FREQ_EST 8'h07
`define RSPH_ADDR_RATE 8'h08
`define RSPH_ADDR_STATUS 8'h09
`define RSPH_ADDR_RX_DATA 8'h0a
`define RSPH_ADDR_COMMAND 8'h0b
`define RSPH_SYNC_HIGH_RST 8'hd3
`define RSPH_SYNC_LOW_RST 8'h91
`define RSPH_PKT_LEN_RST 8'hff
`define RSPH_PKT_CTRL_RST 8'h05
`define RSPH_MODEM_RST 8'h02
`define RSPH_OFFSET_CFG_RST 8'h36
`define RSPH_RATE_RST 16'h0100
// Packet control fields
`define RSPH_PC_LEN_LO 0
`define RSPH_PC_CRC_EN 2
`define RSPH_PC_APPEND 3
`define RSPH_PC_EXIT_RX 4
// Modem config fields
`define RSPH_MD_SYNC_LO 0
`define RSPH_MD_MOD_LO 4
`define RSPH_MOD_OOK 3'h3
// Offset config fields
`define RSPH_OC_RANGE_LO 0
`define RSPH_OC_POST_LO 2
`define RSPH_OC_PRE_LO 3
`define RSPH_OC_CS_GATE 5
// Commands
`define RSPH_CMD_RX 8'h01
`define RSPH_CMD_IDLE 8'h02
// Sync thresholds
`define RSPH_THR_15 5'd15
`define RSPH_THR_16 5'd16
`define RSPH_THR_30 6'd30
`define RSPH_CRC_INIT 16'hffff
`define RSPH_CRC_POLY 16'h8005
`endif

// ---- rsph_pkg.sv ----
// Types for the receive sync and packet handler
package rsph_pkg;
    typedef enum logic [2:0] {
        RSPH_IDLE = 3'b000,
        RSPH_SEARCH = 3'b001,
        RSPH_LENGTH = 3'b010,
        RSPH_PAYLOAD = 3'b011,
        RSPH_CRC = 3'b100,
        RSPH_STAT1 = 3'b101,
        RSPH_STAT2 = 3'b110
    } rsph_state_t;
    typedef struct packed {
        logic [15:0] accum;
        logic [2:0] ph;
        logic bit_out;
        logic bit_valid;
        logic prev;
    } rsph_bsync_t;
    typedef struct packed {
        logic [7:0] est;
        logic [7:0] hold_cnt;
    } rsph_foc_t;
    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } rsph_byte_t;
endpackage : rsph_pkg

// ---- rsph_bit_sync.sv ----
// Bit synchroniser recovering symbol timing from a sampled data pin
`timescale 1ns/10ps
`include "rsph_params.svh"
module rsph_bit_sync
    import rsph_pkg::*;
(
    input wire logic clock, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic enable, // Receiver active
    input wire logic [15:0] rate_step, // Phase step per clock
    input wire logic rx_bit, // Synchronised data level
    output logic bit_out, // Recovered bit
    output logic bit_valid // One pulse per symbol
);
    rsph_bsync_t s;
    rsph_bsync_t next_s;
    // Phase accumulator wraps once per symbol; edges pull it to mid-symbol
    always_comb begin
        next_s = s;
        next_s.bit_valid = 1'b0;
        next_s.prev = rx_bit;
        if (!enable) begin
            next_s.accum = 16'h0000;
        end else if (rx_bit != s.prev) begin
            // Continuous retiming on every transition [RULE5]
            next_s.accum = 16'h8000;
        end else begin
            {next_s.bit_valid, next_s.accum} = {1'b0, s.accum} + {1'b0, rate_step}; // [RULE5]
            next_s.bit_out = rx_bit;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
    assign bit_out = s.bit_out;
    assign bit_valid = s.bit_valid;
    a_valid_needs_en: assert property (@(posedge clock) disable iff (!rst_n)
        bit_valid |-> $past(enable)) else $error("bit strobe while receiver off"); // [RULE5]
endmodule : rsph_bit_sync

// ---- rsph_offset_track.sv ----
// Frequency offset tracking loop with carrier gate and two gains
`timescale 1ns/10ps
`include "rsph_params.svh"
module rsph_offset_track
    import rsph_pkg::*;
(
    input wire logic clock, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic enable, // Receiver active
    input wire logic [7:0] cfg, // Offset compensation config
    input wire logic is_ook, // OOK format selected
    input wire logic carrier, // Carrier sense, synchronised
    input wire logic sync_found, // Sync word seen since the receiver left idle
    input wire logic [7:0] freq_err, // Error sample, signed
    input wire logic err_valid, // Error sample strobe
    output logic [7:0] estimate // Current offset estimate
);
    rsph_foc_t s;
    rsph_foc_t next_s;
    logic [2:0] shift;
    logic [7:0] limit;
    logic signed [8:0] sum;
    // Smaller shift means faster but noisier settling
    always_comb begin
        shift = sync_found ? {1'b0, cfg[`RSPH_OC_POST_LO +: 1], 1'b1} + 3'd1
                           : {1'b0, cfg[`RSPH_OC_PRE_LO +: 2]}; // [RULE2]
        limit = 8'h7f >> (3'd3 - {1'b0, cfg[`RSPH_OC_RANGE_LO +: 2]});
        sum = $signed({s.est[7], s.est}) + ($signed({freq_err[7], freq_err}) >>> shift);
        next_s = s;
        next_s.hold_cnt = 8'h00;
        if (!enable || is_ook) begin
            next_s.est = 8'h00; // [RULE3]
        end else if (cfg[`RSPH_OC_CS_GATE] && !carrier) begin
            next_s.est = s.est; // [RULE1]
        end else if (err_valid) begin
            if (sum > $signed({1'b0, limit})) begin
                next_s.est = limit;
            end else if (sum < -$signed({1'b0, limit})) begin
                next_s.est = 8'(-limit);
            end else begin
                next_s.est = sum[7:0];
            end
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
    assign estimate = s.est;
    a_gate_freeze: assert property (@(posedge clock) disable iff (!rst_n)
        (enable && !is_ook && cfg[`RSPH_OC_CS_GATE] && !carrier) |=> $stable(estimate))
        else $error("offset moved while gated"); // [RULE1]
    a_ook_zero: assert property (@(posedge clock) disable iff (!rst_n)
        is_ook |=> estimate == 8'h00) else $error("offset applied in OOK"); // [RULE3]
endmodule : rsph_offset_track

// ---- rsph_packet_rx.sv ----
// Receive sync search and packet handler top level
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/10ps
`include "rsph_params.svh"
module rsph_packet_rx
    import rsph_pkg::*;
(
    input wire logic clock, // 25 MHz system clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [7:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Register write data
    input wire logic reg_write, // Write strobe
    input wire logic reg_read, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic rx_data_pin, // Demodulated bit stream
    input wire logic carrier_pin, // Carrier sense level
    input wire logic [7:0] rssi_value, // Signal strength, same clock
    input wire logic [7:0] freq_err, // Frequency error sample
    input wire logic freq_err_valid, // Error sample strobe
    output logic [7:0] synth_offset, // Synthesizer offset drive
    output logic [7:0] fifo_data, // Byte into receive FIFO
    output logic fifo_write, // FIFO write strobe
    output logic sync_seen, // Pulse at sync detection
    output logic packet_done, // Pulse at packet end
    output logic rx_active // Receiver not idle
);
    typedef struct packed {
        rsph_state_t st;
        logic [7:0] sync_hi;
        logic [7:0] sync_lo;
        logic [7:0] pkt_len;
        logic [7:0] pkt_ctrl;
        logic [7:0] modem;
        logic [7:0] off_cfg;
        logic [7:0] synth_off;
        logic [15:0] rate;
        logic [31:0] shreg;
        logic [2:0] bit_cnt;
        logic [7:0] byte_cnt;
        logic [7:0] len_target;
        logic [15:0] crc;
        logic crc_ok;
        logic [1:0] crc_bytes;
        logic sync_hit;
        logic [7:0] rdata;
        rsph_byte_t out;
        logic sync_pulse;
        logic done_pulse;
        logic [1:0] data_sync;
        logic [1:0] cs_sync;
    } rsph_top_t;
    rsph_top_t s;
    rsph_top_t next_s;
    logic rx_bit;
    logic rx_valid;
    logic [7:0] estimate;
    logic [4:0] match_hi;
    logic [4:0] match_lo;
    logic [5:0] match_all;
    logic sync_match;
    logic [7:0] new_byte;
    logic byte_done;
    logic [1:0] len_mode;
    logic [15:0] crc_next;
    logic [31:0] sync_word;
    logic [2:0] smode;
    logic [31:0] diff;
    // Data and carrier pins are asynchronous; read second stages only
    rsph_bit_sync u_bit_sync (
        .clock(clock),
        .rst_n(rst_n),
        .enable(s.st != RSPH_IDLE),
        .rate_step(s.rate),
        .rx_bit(s.data_sync[1]),
        .bit_out(rx_bit),
        .bit_valid(rx_valid)
    );
    rsph_offset_track u_offset (
        .clock(clock),
        .rst_n(rst_n),
        .enable(s.st != RSPH_IDLE),
        .cfg(s.off_cfg),
        .is_ook(s.modem[`RSPH_MD_MOD_LO +: 3] == `RSPH_MOD_OOK),
        .carrier(s.cs_sync[1]),
        .sync_found(s.sync_hit),
        .freq_err(freq_err),
        .err_valid(freq_err_valid),
        .estimate(estimate)
    );
    // Per-bit correlation against the configured word
    assign sync_word = {s.sync_hi, s.sync_lo, s.sync_hi, s.sync_lo}; // [RULE9]
    assign diff = {s.shreg[30:0], rx_bit} ^ sync_word;
    always_comb begin
        match_hi = 5'd0;
        match_lo = 5'd0;
        for (int i = 0; i < 16; i++) begin
            match_lo = match_lo + 5'(!diff[i]);
            match_hi = match_hi + 5'(!diff[i + 16]);
        end
        match_all = {1'b0, match_lo} + {1'b0, match_hi};
    end
    assign smode = s.modem[`RSPH_MD_SYNC_LO +: 3];
    // Threshold by sync mode, modes 3 and 7 need the doubled word
    always_comb begin
        case (smode[1:0])
            2'd1: sync_match = match_lo >= `RSPH_THR_15; // [RULE7]
            2'd2: sync_match = match_lo >= `RSPH_THR_16; // [RULE7]
            2'd3: sync_match = match_all >= `RSPH_THR_30; // [RULE7] [RULE9]
            default: sync_match = 1'b1;
        endcase
        if (smode[2] && !s.cs_sync[1]) begin
            sync_match = 1'b0;
        end
    end
    assign len_mode = s.pkt_ctrl[`RSPH_PC_LEN_LO +: 2];
    assign new_byte = {s.shreg[6:0], rx_bit}; // MSB first [RULE6]
    assign byte_done = rx_valid && s.bit_cnt == 3'd7;
    // Byte-wise CRC, polynomial over the received byte
    always_comb begin
        crc_next = s.crc;
        for (int b = 7; b >= 0; b--) begin
            crc_next = (crc_next[15] ^ new_byte[b]) ? ((crc_next << 1) ^ `RSPH_CRC_POLY) : (crc_next << 1);
        end
    end
    // Packet state machine and register file
    always_comb begin
        next_s = s;
        next_s.data_sync = {s.data_sync[0], rx_data_pin};
        next_s.cs_sync = {s.cs_sync[0], carrier_pin};
        next_s.out.valid = 1'b0;
        next_s.sync_pulse = 1'b0;
        next_s.done_pulse = 1'b0;
        next_s.rdata = 8'h00;
        if (rx_valid) begin
            next_s.shreg = {s.shreg[30:0], rx_bit};
            next_s.bit_cnt = s.bit_cnt + 3'd1;
        end
        case (s.st)
            RSPH_IDLE: begin
                next_s.sync_hit = 1'b0;
            end
            RSPH_SEARCH: begin
                // Nothing reaches the FIFO until the word matches [RULE8]
                if (rx_valid && sync_match) begin
                    next_s.bit_cnt = 3'd0;
                    next_s.byte_cnt = 8'h00; // [RULE24]
                    next_s.crc = `RSPH_CRC_INIT;
                    next_s.sync_hit = 1'b1;
                    next_s.sync_pulse = 1'b1;
                    next_s.st = (len_mode == 2'd1) ? RSPH_LENGTH : RSPH_PAYLOAD; // [RULE14]
                end
            end
            RSPH_LENGTH: begin
                if (byte_done) begin
                    next_s.crc = crc_next;
                    if (new_byte > s.pkt_len || new_byte == 8'h00) begin
                        next_s.st = RSPH_SEARCH; // [RULE16] [RULE23] [RULE18]
                    end else begin
                        next_s.len_target = new_byte; // [RULE16]
                        next_s.out = '{data: new_byte, valid: 1'b1};
                        next_s.st = RSPH_PAYLOAD;
                    end
                end
            end
            RSPH_PAYLOAD: begin
                if (byte_done) begin
                    next_s.crc = crc_next;
                    next_s.byte_cnt = s.byte_cnt + 8'd1;
                    next_s.out = '{data: new_byte, valid: 1'b1};
                    // Fixed compare uses live length register [RULE15] [RULE19] [RULE20] [RULE21]
                    if (len_mode != 2'd2 && s.byte_cnt + 8'd1 == (len_mode == 2'd1 ? s.len_target : s.pkt_len)) begin
                        next_s.crc_bytes = 2'd0;
                        next_s.st = s.pkt_ctrl[`RSPH_PC_CRC_EN] ? RSPH_CRC : RSPH_STAT1; // [RULE22]
                    end
                end
            end
            RSPH_CRC: begin
                if (byte_done) begin
                    next_s.crc = crc_next;
                    next_s.crc_bytes = s.crc_bytes + 2'd1;
                    if (s.crc_bytes == 2'd1) begin
                        next_s.st = RSPH_STAT1;
                    end
                end
            end
            RSPH_STAT1: begin
                next_s.crc_ok = !s.pkt_ctrl[`RSPH_PC_CRC_EN] || s.crc == 16'h0000; // [RULE22]
                if (s.pkt_ctrl[`RSPH_PC_APPEND]) begin
                    next_s.out = '{data: rssi_value, valid: 1'b1}; // [RULE10] [RULE11]
                    next_s.st = RSPH_STAT2;
                end else begin
                    next_s.done_pulse = 1'b1;
                    next_s.st = s.pkt_ctrl[`RSPH_PC_EXIT_RX] ? RSPH_SEARCH : RSPH_IDLE; // [RULE20]
                end
            end
            RSPH_STAT2: begin
                next_s.out = '{data: {s.crc_ok, 7'h00}, valid: 1'b1}; // [RULE10] [RULE12]
                next_s.done_pulse = 1'b1;
                next_s.st = s.pkt_ctrl[`RSPH_PC_EXIT_RX] ? RSPH_SEARCH : RSPH_IDLE; // [RULE20]
            end
            default: next_s.st = RSPH_IDLE;
        endcase
        // Register writes; length and control stay writable in receive [RULE19]
        if (reg_write) begin
            case (reg_addr)
                `RSPH_ADDR_SYNC_HIGH: next_s.sync_hi = reg_wdata;
                `RSPH_ADDR_SYNC_LOW: next_s.sync_lo = reg_wdata;
                `RSPH_ADDR_PKT_LEN: next_s.pkt_len = reg_wdata;
                `RSPH_ADDR_PKT_CTRL: next_s.pkt_ctrl = reg_wdata;
                `RSPH_ADDR_MODEM: next_s.modem = reg_wdata;
                `RSPH_ADDR_OFFSET_CFG: next_s.off_cfg = reg_wdata;
                `RSPH_ADDR_SYNTH_OFF: next_s.synth_off = reg_wdata; // [RULE4]
                `RSPH_ADDR_RATE: next_s.rate = {reg_wdata, s.rate[15:8]};
                `RSPH_ADDR_COMMAND: begin
                    // Stop command ends infinite reception [RULE17]
                    if (reg_wdata == `RSPH_CMD_RX) begin
                        next_s.st = RSPH_SEARCH;
                    end else if (reg_wdata == `RSPH_CMD_IDLE) begin
                        next_s.st = RSPH_IDLE;
                    end
                end
                default: ;
            endcase
        end
        // Read data in the cycle after the strobe
        if (reg_read) begin
            case (reg_addr)
                `RSPH_ADDR_SYNC_HIGH: next_s.rdata = s.sync_hi;
                `RSPH_ADDR_SYNC_LOW: next_s.rdata = s.sync_lo;
                `RSPH_ADDR_PKT_LEN: next_s.rdata = s.pkt_len;
                `RSPH_ADDR_PKT_CTRL: next_s.rdata = s.pkt_ctrl;
                `RSPH_ADDR_MODEM: next_s.rdata = s.modem;
                `RSPH_ADDR_OFFSET_CFG: next_s.rdata = s.off_cfg;
                `RSPH_ADDR_SYNTH_OFF: next_s.rdata = s.synth_off;
                `RSPH_ADDR_FREQ_EST: next_s.rdata = estimate; // [RULE4]
                `RSPH_ADDR_RATE: next_s.rdata = s.rate[7:0];
                `RSPH_ADDR_STATUS: next_s.rdata = {4'h0, s.crc_ok, s.st};
                `RSPH_ADDR_RX_DATA: next_s.rdata = s.out.data;
                default: next_s.rdata = 8'h00;
            endcase
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.sync_hi <= `RSPH_SYNC_HIGH_RST;
            s.sync_lo <= `RSPH_SYNC_LOW_RST;
            s.pkt_len <= `RSPH_PKT_LEN_RST;
            s.pkt_ctrl <= `RSPH_PKT_CTRL_RST;
            s.modem <= `RSPH_MODEM_RST;
            s.off_cfg <= `RSPH_OFFSET_CFG_RST;
            s.rate <= `RSPH_RATE_RST;
        end else begin
            s <= next_s;
        end
    end
    // Synth drive adds the written offset [RULE4]
    assign synth_offset = s.synth_off;
    assign reg_rdata = s.rdata;
    assign fifo_data = s.out.data;
    assign fifo_write = s.out.valid;
    assign sync_seen = s.sync_pulse;
    assign packet_done = s.done_pulse;
    assign rx_active = s.st != RSPH_IDLE;
    a_count_cleared: assert property (@(posedge clock) disable iff (!rst_n)
        sync_seen |-> s.byte_cnt == 8'h00) else $error("count not cleared at sync"); // [RULE24]
    a_no_write_search: assert property (@(posedge clock) disable iff (!rst_n)
        ($past(s.st) == RSPH_SEARCH && s.st == RSPH_SEARCH) |-> !fifo_write)
        else $error("FIFO written before sync"); // [RULE8]
    a_status_order: assert property (@(posedge clock) disable iff (!rst_n)
        (s.st == RSPH_STAT2) |=> fifo_write && fifo_data[6:0] == 7'h00) else $error("bad status byte two"); // [RULE12]
    a_rssi_first: assert property (@(posedge clock) disable iff (!rst_n)
        (s.st == RSPH_STAT1 && s.pkt_ctrl[`RSPH_PC_APPEND] && !reg_write) |=> fifo_data == $past(rssi_value))
        else $error("status byte one not RSSI"); // [RULE11]
    a_oversize_drop: assert property (@(posedge clock) disable iff (!rst_n)
        (s.st == RSPH_LENGTH && byte_done && new_byte > s.pkt_len && !reg_write) |=> s.st == RSPH_SEARCH && !fifo_write)
        else $error("oversize packet kept"); // [RULE23]
    a_fixed_end: assert property (@(posedge clock) disable iff (!rst_n)
        (s.st == RSPH_PAYLOAD && len_mode == 2'd0 && byte_done && s.byte_cnt + 8'd1 == s.pkt_len && !reg_write)
        |=> s.st != RSPH_PAYLOAD) else $error("fixed packet overran"); // [RULE19]
    a_infinite_runs: assert property (@(posedge clock) disable iff (!rst_n)
        (s.st == RSPH_PAYLOAD && len_mode == 2'd2 && !reg_write) |=> s.st == RSPH_PAYLOAD)
        else $error("infinite mode ended"); // [RULE17]
endmodule : rsph_packet_rx

// ---- rsph_tx_model.sv ----
// Far-end transmitter model sending framed bit streams
`timescale 1ns/10ps
module rsph_tx_model #(
    parameter int BIT_CLKS = 8 // Clocks per symbol
) (
    input wire logic clock, // System clock
    output logic tx_bit // Bit stream toward the receiver
);
    initial tx_bit = 1'b0;
    // Preamble then caller bytes; slow stretches one bit per byte to mimic rate error
    task automatic send(input logic [7:0] q[$], input bit slow);
        logic [7:0] f[$];
        f = {8'haa, 8'haa, 8'haa, 8'haa, q};
        foreach (f[i]) begin
            for (int b = 7; b >= 0; b--) begin
                @(posedge clock);
                tx_bit <= f[i][b];
                repeat (BIT_CLKS - 1 + int'(slow && b == 0)) @(posedge clock);
            end
        end
        // A released line must not look like a held last bit
        @(posedge clock);
        tx_bit <= ~f[f.size()-1][0];
    endtask : send
endmodule : rsph_tx_model

// ---- rsph_packet_rx_test.sv ----
// Self-checking bench for the receive sync and packet handler
`timescale 1ns/10ps
`include "rsph_params.svh"
module rsph_packet_rx_test;
    localparam logic [15:0] SW = 16'h9b4e;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rssi_value = 8'h00, freq_err = 8'h00;
    logic reg_write = 1'b0, reg_read = 1'b0, carrier_pin = 1'b0, freq_err_valid = 1'b0, rd_d = 1'b0;
    logic rx_data_pin, fifo_write, sync_seen, packet_done, rx_active;
    logic [7:0] reg_rdata, synth_offset, fifo_data;
    logic [7:0] rq[$], fq[$];
    int mismatches = 0, comparisons = 0, syncs = 0;

    rsph_tx_model tx (.clock(clock), .tx_bit(rx_data_pin));
    rsph_packet_rx uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .rx_data_pin(rx_data_pin),
        .carrier_pin(carrier_pin), .rssi_value(rssi_value), .freq_err(freq_err),
        .freq_err_valid(freq_err_valid), .synth_offset(synth_offset), .fifo_data(fifo_data),
        .fifo_write(fifo_write), .sync_seen(sync_seen), .packet_done(packet_done), .rx_active(rx_active));

    always #20 clock = ~clock;
    // Error samples keep flowing so a loop that fails to hold would drift
    always @(posedge clock) begin
        freq_err <= 8'($urandom);
        freq_err_valid <= 1'($urandom);
    end

    task automatic check(input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task tally_and_finish;
        if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [7:0] a, d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, e);
        @(posedge clock);
        rq.push_back(e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
    endtask : rd

    // Bit-serial CRC, MSB first, so appending it leaves a zero residue
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) c = (c[15] ^ b[i]) ? {c[14:0], 1'b0} ^ `RSPH_CRC_POLY : {c[14:0], 1'b0};
        return c;
    endfunction : crc_byte

    // One frame: configure while idle, note expected FIFO bytes, send
    task automatic run(input logic [7:0] ctl, md, plen, input logic [31:0] sw, input int nb, input bit ok, bad);
        logic [7:0] q[$];
        logic [15:0] c;
        logic [7:0] r;
        int s;
        int n;
        c = `RSPH_CRC_INIT;
        n = syncs;
        r = 8'($urandom);
        wr(`RSPH_ADDR_COMMAND, `RSPH_CMD_IDLE);
        wr(`RSPH_ADDR_PKT_CTRL, ctl);
        wr(`RSPH_ADDR_MODEM, md);
        wr(`RSPH_ADDR_PKT_LEN, plen);
        wr(`RSPH_ADDR_COMMAND, `RSPH_CMD_RX);
        rssi_value <= r;
        if (md[1:0] == 2'h3) q = {sw[31:24], sw[23:16]};
        q.push_back(sw[15:8]);
        q.push_back(sw[7:0]);
        s = q.size();
        if (ctl[1:0] == 2'h1) q.push_back(8'(nb));
        for (int i = 0; i < nb; i++) q.push_back(8'($urandom));
        for (int i = s; i < q.size(); i++) begin
            c = crc_byte(c, q[i]);
            if (ok) fq.push_back(q[i]);
        end
        if (ctl[2]) begin
            q.push_back(c[15:8]);
            q.push_back(c[7:0] ^ {7'h0, bad});
        end
        if (ok && ctl[3]) begin
            fq.push_back(r);
            fq.push_back({~bad, 7'h0});
        end
        fork
            tx.send(q, ctl[1:0] == 2'h2);
            if (ok && ctl[1:0] == 2'h2) begin
                @(posedge sync_seen);
                wr(`RSPH_ADDR_PKT_CTRL, ctl & 8'hfc);
            end
        join
        repeat (60) @(posedge clock);
        // An oversize length byte still counts as one sync detection
        check(8'(syncs - n), 8'(ok || ctl[1:0] == 2'h1));
        if (ok) check({7'h0, rx_active}, {7'h0, ctl[4]});
    endtask : run

    // Result watcher pairs each appearing output with the oldest note
    always @(posedge clock) begin
        rd_d <= reg_read;
        if (sync_seen) syncs++;
        if (rd_d) check(reg_rdata, rq.pop_front());
        if (packet_done) check({7'h0, fifo_write}, 8'h01);
        if (fifo_write && fq.size() == 0) begin
            mismatches++;
            $display("unexpected at %0t: stray fifo byte %h", $time, fifo_data);
        end
        else if (fifo_write) check(fifo_data, fq.pop_front());
    end

    // Seven frames of under 1000 cycles each; the limit leaves a wide margin
    initial begin
        repeat (30000) @(posedge clock);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        logic [7:0] tab[6];
        logic [7:0] v;
        tab = '{`RSPH_SYNC_HIGH_RST, `RSPH_SYNC_LOW_RST, `RSPH_PKT_LEN_RST, `RSPH_PKT_CTRL_RST,
            `RSPH_MODEM_RST, `RSPH_OFFSET_CFG_RST};
        void'($urandom(32'h791a));
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        foreach (tab[i]) rd(8'(i), tab[i]);
        rd(8'h0c, 8'h00);
        v = 8'($urandom);
        wr(`RSPH_ADDR_SYNTH_OFF, v);
        rd(`RSPH_ADDR_SYNTH_OFF, v);
        check(synth_offset, v);
        // Eight clocks per bit: low byte first, high byte lands second
        wr(`RSPH_ADDR_RATE, 8'h00);
        wr(`RSPH_ADDR_RATE, 8'h20);
        wr(`RSPH_ADDR_SYNC_HIGH, SW[15:8]);
        wr(`RSPH_ADDR_SYNC_LOW, SW[7:0]);
        // Gate set and no carrier, then OOK with carrier: estimate must stay put
        wr(`RSPH_ADDR_COMMAND, `RSPH_CMD_RX);
        repeat (50) @(posedge clock);
        rd(`RSPH_ADDR_FREQ_EST, 8'h00);
        wr(`RSPH_ADDR_COMMAND, `RSPH_CMD_IDLE);
        wr(`RSPH_ADDR_MODEM, 8'h32);
        carrier_pin <= 1'b1;
        wr(`RSPH_ADDR_COMMAND, `RSPH_CMD_RX);
        repeat (50) @(posedge clock);
        rd(`RSPH_ADDR_FREQ_EST, 8'h00);
        run(8'h0d, 8'h02, 8'h10, {16'h0, SW}, 3, 1, 0);
        run(8'h0d, 8'h06, 8'h10, {16'h0, SW}, 4, 1, 1);
        run(8'h0d, 8'h02, 8'h04, {16'h0, SW}, 5, 0, 0);
        check({7'h0, rx_active}, 8'h01);
        run(8'h08, 8'h01, 8'h02, {16'h0, SW ^ 16'h0400}, 2, 1, 0);
        run(8'h08, 8'h02, 8'h02, {16'h0, SW ^ 16'h0400}, 2, 0, 0);
        run(8'h18, 8'h03, 8'h01, {SW ^ 16'h0010, SW ^ 16'h2000}, 1, 1, 0);
        run(8'h0e, 8'h02, 8'h06, {16'h0, SW}, 6, 1, 0);
        check(8'(fq.size()), 8'h00);
        tally_and_finish();
    end
endmodule : rsph_packet_rx_test
